// [design/clock_detect_filter.sv]
// Qualifies the raw clock-activity indication into a locked status.
`include "clock_skew_map.svh"
`default_nettype none

module clock_detect_filter (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       activity,
  input  wire logic [1:0] thresholdCode,
  output logic            locked
);

  clock_skew_pkg::detect_state_t state_r;
  clock_skew_pkg::detect_state_t state_nxt;
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic [7:0] qualLen;

  // Slow sample rates need a longer window of unbroken activity before lock is claimed.
  // Undefined threshold codes fall back to the fast setting.
  assign qualLen = (thresholdCode == `THRESH_SLOW) ?
                   8'(`QUAL_SLOW_CYC) : 8'(`QUAL_FAST_CYC);

  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    unique case (state_r)
      clock_skew_pkg::DET_SEARCH: begin
        count_nxt = 8'h00;
        if (activity) begin
          state_nxt = clock_skew_pkg::DET_QUALIFY;
          count_nxt = 8'h01;
        end
      end
      clock_skew_pkg::DET_QUALIFY: begin
        if (!activity) begin
          state_nxt = clock_skew_pkg::DET_SEARCH;
          count_nxt = 8'h00;
        end else if (count_r >= qualLen) begin
          state_nxt = clock_skew_pkg::DET_LOCKED;
        end else begin
          count_nxt = count_r + 8'h01;
        end
      end
      clock_skew_pkg::DET_LOCKED: begin
        if (!activity) begin
          state_nxt = clock_skew_pkg::DET_SEARCH;
          count_nxt = 8'h00;
        end
      end
      default: begin
        state_nxt = clock_skew_pkg::DET_SEARCH;
        count_nxt = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= clock_skew_pkg::DET_SEARCH;
      count_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
    end
  end

  assign locked = (state_r == clock_skew_pkg::DET_LOCKED);

endmodule

`default_nettype wire

// [design/clock_skew_map.svh]
// Register indices, field positions, reset values and timing counts.
`ifndef CLOCK_SKEW_MAP_SVH
`define CLOCK_SKEW_MAP_SVH

// Register indices; the byte address on the bus is four times the index.
`define IDX_DELAY_MODE        12'h110
`define IDX_ANALOG_FINE       12'h112
`define IDX_DIGITAL_SUPERFINE 12'h113
`define IDX_DIGITAL_FINE      12'h114
`define IDX_DETECT_CONFIG     12'h11A
`define IDX_PRESENCE_STATUS   12'h11B
`define IDX_IRQ_STATUS        12'h130
`define IDX_IRQ_MASK          12'h131

// Reset values.
`define RST_DELAY_MODE        3'h0
`define RST_ANALOG_FINE       8'hC0
`define RST_DIGITAL_SUPERFINE 8'h00
`define RST_DIGITAL_FINE      8'hC0
`define RST_DETECT_CONFIG     8'h0E
`define RST_IRQ_MASK          2'h0

// Step limits of the delay lines.
`define FINE_MAX_STEPS        8'hC0
`define FINE_LIMITED_STEPS    8'h10
`define SUPERFINE_MAX_STEPS   8'h80

// Field positions.
`define DET_THRESH_MSB        4
`define DET_THRESH_LSB        3
`define IRQ_LOCK_GAINED       0
`define IRQ_LOCK_LOST         1

// Threshold codes.
`define THRESH_FAST           2'h1
`define THRESH_SLOW           2'h3

// Qualification times before the clock is reported as locked.
`define CLK_PERIOD_NS         10
`define QUAL_FAST_NS          320
`define QUAL_SLOW_NS          1280
`define QUAL_FAST_CYC \
  ((`QUAL_FAST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define QUAL_SLOW_CYC \
  ((`QUAL_SLOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [design/clock_skew_pkg.sv]
// Types shared by the sample-clock skew and detection block.
`default_nettype none

package clock_skew_pkg;

  typedef enum logic [2:0] {
    MODE_NONE          = 3'b000,
    MODE_FINE_SHORT    = 3'b010,
    MODE_FINE_SHORT_LJ = 3'b011,
    MODE_FINE_FULL     = 3'b100,
    MODE_SUPERFINE     = 3'b110
  } delay_mode_t;

  typedef enum logic [1:0] {
    DET_SEARCH  = 2'b00,
    DET_QUALIFY = 2'b01,
    DET_LOCKED  = 2'b10
  } detect_state_t;

endpackage

`default_nettype wire

// [design/sample_clock_delay_and_detect.sv]
// Sample-clock skew registers, delay application and clock detection.
//
// Function
// - Analog fine delay: 8-bit count of 1.725 ps steps, resets to 192.
// - Analog fine delay applies only in delay modes 2, 3, 4 or 6.
// - Digital super-fine delay: 8-bit, 0.25 ps steps, max 128, resets 0.
// - Digital super-fine delay applies only in delay modes 010 or 110.
// - Digital fine: 8-bit, 1.725 ps steps, resets 192, modes 2,3,4,6.
// - Detection threshold bits 4:3: 01 at or above 300 MSPS, 11 below.
// - Status bit 0 reads 1 when input clock detected and locked.
// - Detect config bits 7:5 reset zero, bits 2:0 reset 6, writable.
// - Mode 000 none, 010/011 fine 0-16, 100 fine 192, 110 super-fine.
//
// Decided for this implementation: the AHB-Lite register port.
`include "clock_skew_map.svh"
`default_nettype none

module sample_clock_delay_and_detect (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        clockActivity,
  output logic [2:0]       delayMode,
  output logic [7:0]       analogFineDelay,
  output logic [7:0]       digitalFineDelay,
  output logic [7:0]       digitalSuperfineDelay,
  output logic             analogFineEnable,
  output logic             digitalFineEnable,
  output logic             superfineEnable,
  output logic             clockLocked,
  output logic             irq
);

  // Delay mode decoding, shared by both fine paths and the super-fine path.
  function automatic logic fineUsed(input logic [2:0] mode);
    return (mode == clock_skew_pkg::MODE_FINE_SHORT)    ||
           (mode == clock_skew_pkg::MODE_FINE_SHORT_LJ) ||
           (mode == clock_skew_pkg::MODE_FINE_FULL)     ||
           (mode == clock_skew_pkg::MODE_SUPERFINE);
  endfunction

  function automatic logic superfineUsed(input logic [2:0] mode);
    return (mode == clock_skew_pkg::MODE_FINE_SHORT) ||
           (mode == clock_skew_pkg::MODE_SUPERFINE);
  endfunction

  // The short fine modes only have the first sixteen steps.
  function automatic logic [7:0] fineLimit(input logic [2:0] mode);
    if ((mode == clock_skew_pkg::MODE_FINE_SHORT) ||
        (mode == clock_skew_pkg::MODE_FINE_SHORT_LJ)) begin
      return `FINE_LIMITED_STEPS;
    end
    return `FINE_MAX_STEPS;
  endfunction

  function automatic logic [7:0] clampSteps(input logic [7:0] value,
                                            input logic [7:0] limit);
    return (value > limit) ? limit : value;
  endfunction

  // ---------------------------------------------------------------
  // Bus address phase capture.
  // ---------------------------------------------------------------
  logic        addrTaken;
  logic        wrPhase_r;
  logic        rdPhase_r;
  logic        rdWait_r;
  logic [11:0] phaseIdx_r;
  logic        phaseMapped_r;
  logic        idxInRange;

  assign addrTaken  = hsel && htrans[1] && hready;
  assign idxInRange = (haddr[31:14] == 18'h00000) && (haddr[1:0] == 2'h0);

  always_ff @(posedge clock) begin
    if (reset) begin
      wrPhase_r     <= 1'b0;
      rdPhase_r     <= 1'b0;
      phaseIdx_r    <= 12'h000;
      phaseMapped_r <= 1'b0;
    end else if (addrTaken) begin
      wrPhase_r     <= hwrite;
      rdPhase_r     <= !hwrite;
      phaseIdx_r    <= haddr[13:2];
      phaseMapped_r <= idxInRange;
    end else if (hreadyout) begin
      wrPhase_r     <= 1'b0;
      rdPhase_r     <= 1'b0;
    end
  end

  // Reads take one wait state so a write just before them is visible.
  always_ff @(posedge clock) begin
    if (reset) begin
      rdWait_r <= 1'b0;
    end else begin
      rdWait_r <= addrTaken && !hwrite;
    end
  end

  assign hreadyout = !rdWait_r;
  assign hresp     = 1'b0;

  // ---------------------------------------------------------------
  // Register selects for the data phase.
  // ---------------------------------------------------------------
  logic selMode;
  logic selAnalogFine;
  logic selSuperfine;
  logic selDigitalFine;
  logic selDetectCfg;
  logic selStatus;
  logic selIrqStatus;
  logic selIrqMask;
  logic wrStrobe;

  assign selMode        = phaseMapped_r && (phaseIdx_r == `IDX_DELAY_MODE);
  assign selAnalogFine  = phaseMapped_r && (phaseIdx_r == `IDX_ANALOG_FINE);
  assign selSuperfine   = phaseMapped_r &&
                          (phaseIdx_r == `IDX_DIGITAL_SUPERFINE);
  assign selDigitalFine = phaseMapped_r && (phaseIdx_r == `IDX_DIGITAL_FINE);
  assign selDetectCfg   = phaseMapped_r && (phaseIdx_r == `IDX_DETECT_CONFIG);
  assign selStatus      = phaseMapped_r &&
                          (phaseIdx_r == `IDX_PRESENCE_STATUS);
  assign selIrqStatus   = phaseMapped_r && (phaseIdx_r == `IDX_IRQ_STATUS);
  assign selIrqMask     = phaseMapped_r && (phaseIdx_r == `IDX_IRQ_MASK);
  assign wrStrobe       = wrPhase_r;

  // ---------------------------------------------------------------
  // Software registers.
  // ---------------------------------------------------------------
  logic [2:0] delayMode_r;
  logic [7:0] analogFine_r;
  logic [7:0] superfine_r;
  logic [7:0] digitalFine_r;
  logic [7:0] detectCfg_r;
  logic [1:0] irqStatus_r;
  logic [1:0] irqStatus_nxt;
  logic [1:0] irqMask_r;

  always_ff @(posedge clock) begin
    if (reset) begin
      delayMode_r <= `RST_DELAY_MODE;
    end else if (wrStrobe && selMode) begin
      delayMode_r <= hwdata[2:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      analogFine_r <= `RST_ANALOG_FINE;
    end else if (wrStrobe && selAnalogFine) begin
      analogFine_r <= hwdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      superfine_r <= `RST_DIGITAL_SUPERFINE;
    end else if (wrStrobe && selSuperfine) begin
      superfine_r <= hwdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      digitalFine_r <= `RST_DIGITAL_FINE;
    end else if (wrStrobe && selDigitalFine) begin
      digitalFine_r <= hwdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      detectCfg_r <= `RST_DETECT_CONFIG;
    end else if (wrStrobe && selDetectCfg) begin
      detectCfg_r <= hwdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      irqMask_r <= `RST_IRQ_MASK;
    end else if (wrStrobe && selIrqMask) begin
      irqMask_r <= hwdata[1:0];
    end
  end

  // ---------------------------------------------------------------
  // Clock detection.
  // ---------------------------------------------------------------
  logic       lockedNow;
  logic       lockedPrev_r;
  logic [1:0] thresholdCode;
  logic [1:0] irqEvents;

  assign thresholdCode = detectCfg_r[`DET_THRESH_MSB:`DET_THRESH_LSB];

  clock_detect_filter detector (
    .clock         (clock),
    .reset         (reset),
    .activity      (clockActivity),
    .thresholdCode (thresholdCode),
    .locked        (lockedNow)
  );

  always_ff @(posedge clock) begin
    if (reset) begin
      lockedPrev_r <= 1'b0;
    end else begin
      lockedPrev_r <= lockedNow;
    end
  end

  assign irqEvents[`IRQ_LOCK_GAINED] = lockedNow && !lockedPrev_r;
  assign irqEvents[`IRQ_LOCK_LOST]   = !lockedNow && lockedPrev_r;

  // A new event in the cycle of a write-one clear keeps its bit set.
  always_comb begin
    irqStatus_nxt = irqStatus_r;
    if (wrStrobe && selIrqStatus) begin
      irqStatus_nxt = irqStatus_r & ~hwdata[1:0];
    end
    irqStatus_nxt = irqStatus_nxt | irqEvents;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      irqStatus_r <= 2'h0;
    end else begin
      irqStatus_r <= irqStatus_nxt;
    end
  end

  assign irq = |(irqStatus_r & irqMask_r);

  // ---------------------------------------------------------------
  // Delay application. Index 0 is the analog path, 1 the digital.
  // ---------------------------------------------------------------
  logic [7:0] fineSetting [2];
  logic [7:0] fineApplied [2];
  logic [7:0] fineOut_r   [2];
  logic [7:0] superApplied;
  logic [7:0] superOut_r;
  logic       fineOn;
  logic       superOn;
  logic       fineEn_r;
  logic       superEn_r;

  assign fineSetting[0] = analogFine_r;
  assign fineSetting[1] = digitalFine_r;

  assign fineOn  = fineUsed(delayMode_r);
  assign superOn = superfineUsed(delayMode_r);

  // Codes above 192 are undefined, so the line is held at its last step
  // instead of wrapping onto a short delay.
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : finePath
      assign fineApplied[g] = fineOn ?
        clampSteps(fineSetting[g], fineLimit(delayMode_r)) : 8'h00;

      always_ff @(posedge clock) begin
        if (reset) begin
          fineOut_r[g] <= 8'h00;
        end else begin
          fineOut_r[g] <= fineApplied[g];
        end
      end
    end
  endgenerate

  assign superApplied = superOn ?
    clampSteps(superfine_r, `SUPERFINE_MAX_STEPS) : 8'h00;

  always_ff @(posedge clock) begin
    if (reset) begin
      superOut_r <= 8'h00;
      fineEn_r   <= 1'b0;
      superEn_r  <= 1'b0;
    end else begin
      superOut_r <= superApplied;
      fineEn_r   <= fineOn;
      superEn_r  <= superOn;
    end
  end

  assign delayMode             = delayMode_r;
  assign analogFineDelay       = fineOut_r[0];
  assign digitalFineDelay      = fineOut_r[1];
  assign digitalSuperfineDelay = superOut_r;
  assign analogFineEnable      = fineEn_r;
  assign digitalFineEnable     = fineEn_r;
  assign superfineEnable       = superEn_r;
  assign clockLocked           = lockedNow;

  // ---------------------------------------------------------------
  // Read data.
  // ---------------------------------------------------------------
  logic [7:0]  statusByte;
  logic [31:0] readMux;

  assign statusByte = {7'h00, lockedNow};

  assign readMux = selMode        ? {29'h0, delayMode_r}   :
                   selAnalogFine  ? {24'h0, analogFine_r}  :
                   selSuperfine   ? {24'h0, superfine_r}   :
                   selDigitalFine ? {24'h0, digitalFine_r} :
                   selDetectCfg   ? {24'h0, detectCfg_r}   :
                   selStatus      ? {24'h0, statusByte}    :
                   selIrqStatus   ? {30'h0, irqStatus_r}   :
                   selIrqMask     ? {30'h0, irqMask_r}     :
                   32'h00000000;

  always_ff @(posedge clock) begin
    if (reset) begin
      hrdata <= 32'h00000000;
    end else if (rdPhase_r && rdWait_r) begin
      hrdata <= readMux;
    end
  end

  // The bus carries only whole words; narrower sizes are served the same.
  logic unusedSize;
  assign unusedSize = ^hsize;

endmodule

`default_nettype wire

// [verification/sample_clock_delay_and_detect_monitor.sv]
// Concurrent checks on the ports of the sample-clock skew block.
`default_nettype none

module sample_clock_delay_and_detect_monitor (
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       clockActivity,
  input wire logic [2:0] delayMode,
  input wire logic [7:0] analogFineDelay,
  input wire logic [7:0] digitalFineDelay,
  input wire logic [7:0] digitalSuperfineDelay,
  input wire logic       analogFineEnable,
  input wire logic       digitalFineEnable,
  input wire logic       superfineEnable,
  input wire logic       clockLocked
);
  logic [7:0] actRun_r;
  logic [7:0] actRun_nxt;
  wire logic  fineMode;
  wire logic  superMode;
  wire logic  taken;

  assign fineMode  = delayMode inside {3'h2, 3'h3, 3'h4, 3'h6};
  assign superMode = delayMode inside {3'h2, 3'h6};
  assign taken     = hsel & htrans[1] & hready;
  // The run length saturates so a long active stretch never wraps to zero.
  assign actRun_nxt = !clockActivity ? 8'h00 :
                      (actRun_r == 8'hFF) ? actRun_r : actRun_r + 8'h01;

  always_ff @(posedge clock) begin
    if (reset) begin
      actRun_r <= 8'h00;
    end else begin
      actRun_r <= actRun_nxt;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  analog_enable_a:
    assert property (analogFineEnable == $past(fineMode))
    else $error("analog fine enable does not follow the mode");
  digital_enable_a:
    assert property (digitalFineEnable == $past(fineMode))
    else $error("digital fine enable does not follow the mode");
  superfine_enable_a:
    assert property (superfineEnable == $past(superMode))
    else $error("super-fine enable does not follow the mode");
  fine_idle_zero_a:
    assert property (!$past(fineMode) |->
      analogFineDelay == 8'h00 && digitalFineDelay == 8'h00)
    else $error("fine delay applied outside fine modes");
  short_clamp_a:
    assert property ($past(delayMode) inside {3'h2, 3'h3} |->
      analogFineDelay <= 8'h10 && digitalFineDelay <= 8'h10)
    else $error("short fine mode exceeds 16 steps");
  fine_range_a:
    assert property (analogFineDelay <= 8'hC0 && digitalFineDelay <= 8'hC0)
    else $error("fine delay beyond 192 steps");
  superfine_range_a:
    assert property (digitalSuperfineDelay <= 8'h80)
    else $error("super-fine delay beyond 128 steps");
  lock_drop_a:
    assert property (!clockActivity |=> !clockLocked)
    else $error("lock held after activity was lost");
  lock_qualify_a:
    assert property ($rose(clockLocked) |-> actRun_r >= 8'h20)
    else $error("lock reported before qualification");
  read_wait_a:
    assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase is not one wait then ready");
  write_wait_a:
    assert property (taken && hwrite |=> hreadyout)
    else $error("write data phase inserted a wait");
endmodule

bind sample_clock_delay_and_detect sample_clock_delay_and_detect_monitor mon (
  .clock(clock), .reset(reset), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .clockActivity(clockActivity), .delayMode(delayMode),
  .analogFineDelay(analogFineDelay), .digitalFineDelay(digitalFineDelay),
  .digitalSuperfineDelay(digitalSuperfineDelay),
  .analogFineEnable(analogFineEnable),
  .digitalFineEnable(digitalFineEnable),
  .superfineEnable(superfineEnable), .clockLocked(clockLocked));

`default_nettype wire

// [verification/sample_clock_delay_and_detect_tb_top.sv]
// Self-checking bench for the sample-clock skew and detection block.
`include "clock_skew_map.svh"
`default_nettype none

module sample_clock_delay_and_detect_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock;
  logic        reset;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire logic   hready;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        clockActivity;
  logic [2:0]  delayMode;
  logic [7:0]  anaF;
  logic [7:0]  digF;
  logic [7:0]  supF;
  logic        anaEn;
  logic        digEn;
  logic        supEn;
  logic        clockLocked;
  logic        irq;
  logic [31:0] rdData;
  int          failCount = 0;
  int          checksDone = 0;
  logic [11:0] rIdx [8] = '{`IDX_DELAY_MODE, `IDX_ANALOG_FINE,
    `IDX_DIGITAL_SUPERFINE, `IDX_DIGITAL_FINE, `IDX_DETECT_CONFIG,
    `IDX_PRESENCE_STATUS, `IDX_IRQ_STATUS, `IDX_IRQ_MASK};
  logic [31:0] rRst [8] = '{32'h0, 32'hC0, 32'h0, 32'hC0, 32'h0E, 32'h0,
    32'h0, 32'h0};

  assign hready = hreadyout;

  sample_clock_delay_and_detect DUT (
    .clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .clockActivity(clockActivity), .delayMode(delayMode),
    .analogFineDelay(anaF), .digitalFineDelay(digF),
    .digitalSuperfineDelay(supF), .analogFineEnable(anaEn),
    .digitalFineEnable(digEn), .superfineEnable(supEn),
    .clockLocked(clockLocked), .irq(irq));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic giveVerdict();
    if (failCount == 0 && checksDone > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      failCount++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Ready is looked at just before the edge that samples it.
  task automatic waitReady();
    int n;
    logic ok;
    n = 0;
    ok = 1'b0;
    while (!ok) begin
      @(negedge clock);
      ok = (hready === 1'b1);
      rdData = hrdata;
      @(posedge clock);
      n++;
      if (!ok && n > 20) begin
        failCount++;
        giveVerdict();
      end
    end
  endtask

  task automatic bus(input logic [11:0] idx, input logic wr,
                     input logic [31:0] d);
    @(posedge clock);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {18'h0, idx, 2'h0};
    waitReady();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitReady();
  endtask

  task automatic rdChk(input logic [11:0] idx, input logic [31:0] exp);
    bus(idx, 1'b0, 32'h0);
    check(rdData, exp);
  endtask

  task automatic waitCyc(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask

  function automatic logic [7:0] fineExp(logic [2:0] m, logic [7:0] v);
    logic [7:0] lim;
    lim = (m inside {3'h2, 3'h3}) ? `FINE_LIMITED_STEPS : `FINE_MAX_STEPS;
    if (!(m inside {3'h2, 3'h3, 3'h4, 3'h6})) return 8'h00;
    return (v > lim) ? lim : v;
  endfunction

  function automatic logic [7:0] supExp(logic [2:0] m, logic [7:0] v);
    if (!(m inside {3'h2, 3'h6})) return 8'h00;
    return (v > `SUPERFINE_MAX_STEPS) ? `SUPERFINE_MAX_STEPS : v;
  endfunction

  initial begin
    logic [7:0] af;
    logic [7:0] df;
    logic [7:0] sf;
    logic [2:0] m;
    int unsigned seed;
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    clockActivity = 1'b0;
    seed = $urandom(32'h2966);
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rdChk(rIdx[i], rRst[i]);
    end
    af = 8'($urandom);
    bus(`IDX_DETECT_CONFIG, 1'b1, {24'h0, af});
    rdChk(`IDX_DETECT_CONFIG, {24'h0, af});
    bus(`IDX_PRESENCE_STATUS, 1'b1, 32'hFF);
    rdChk(`IDX_PRESENCE_STATUS, 32'h0);
    bus(12'h115, 1'b1, 32'h5A);
    rdChk(12'h115, 32'h0);
    check({31'h0, hresp}, 32'h0);
    for (int i = 0; i < 8; i++) begin
      m = 3'(i);
      bus(`IDX_DELAY_MODE, 1'b1, {29'h0, m});
      for (int k = 0; k < 3; k++) begin
        af = (k == 0) ? 8'h11 : 8'($urandom_range(192, 0));
        df = (k == 0) ? 8'hC0 : 8'($urandom_range(192, 0));
        sf = (k == 0) ? 8'h80 : 8'($urandom_range(128, 0));
        bus(`IDX_ANALOG_FINE, 1'b1, {24'h0, af});
        bus(`IDX_DIGITAL_FINE, 1'b1, {24'h0, df});
        bus(`IDX_DIGITAL_SUPERFINE, 1'b1, {24'h0, sf});
        waitCyc(2);
        check({29'h0, delayMode}, {29'h0, m});
        check({24'h0, anaF}, {24'h0, fineExp(m, af)});
        check({24'h0, digF}, {24'h0, fineExp(m, df)});
        check({24'h0, supF}, {24'h0, supExp(m, sf)});
        check({30'h0, anaEn, digEn},
              {30'h0, {2{fineExp(m, 8'h1) != 0}}});
        check({31'h0, supEn}, {31'h0, supExp(m, 8'h1) != 0});
        rdChk(`IDX_ANALOG_FINE, {24'h0, af});
        rdChk(`IDX_DIGITAL_SUPERFINE, {24'h0, sf});
      end
    end
    bus(`IDX_IRQ_MASK, 1'b1, 32'h3);
    bus(`IDX_DETECT_CONFIG, 1'b1, 32'h0E);
    @(posedge clock);
    clockActivity <= 1'b1;
    waitCyc(30);
    check({31'h0, clockLocked}, 32'h0);
    waitCyc(10);
    check({30'h0, irq, clockLocked}, 32'h3);
    rdChk(`IDX_PRESENCE_STATUS, 32'h1);
    bus(`IDX_PRESENCE_STATUS, 1'b1, 32'h0);
    rdChk(`IDX_PRESENCE_STATUS, 32'h1);
    rdChk(`IDX_IRQ_STATUS, 32'h1);
    bus(`IDX_IRQ_STATUS, 1'b1, 32'h1);
    waitCyc(1);
    check({31'h0, irq}, 32'h0);
    @(posedge clock);
    clockActivity <= 1'b0;
    waitCyc(3);
    check({30'h0, irq, clockLocked}, 32'h2);
    rdChk(`IDX_IRQ_STATUS, 32'h2);
    bus(`IDX_IRQ_MASK, 1'b1, 32'h0);
    waitCyc(1);
    check({31'h0, irq}, 32'h0);
    bus(`IDX_IRQ_STATUS, 1'b1, 32'h3);
    bus(`IDX_DETECT_CONFIG, 1'b1, 32'h1E);
    @(posedge clock);
    clockActivity <= 1'b1;
    waitCyc(120);
    check({31'h0, clockLocked}, 32'h0);
    waitCyc(20);
    check({31'h0, clockLocked}, 32'h1);
    giveVerdict();
  end
endmodule

`default_nettype wire
